// *** rtl/aebi_pkg.sv ***
// Shared types and constants for the asynchronous external bus master
package aebi_pkg;

    // Remaining-length encodings driven on the two length outputs
    localparam logic [1:0] LEN_BYTE   = 2'h1;
    localparam logic [1:0] LEN_WORD   = 2'h2;
    localparam logic [1:0] LEN_THREE  = 2'h3;
    localparam logic [1:0] LEN_LONG   = 2'h0;

    // Size acknowledge decode, {size_ack_1, size_ack_0} as seen on pins
    localparam logic [1:0] ACK_WAIT   = 2'h3;
    localparam logic [1:0] ACK_PORT8  = 2'h2;
    localparam logic [1:0] ACK_PORT16 = 2'h1;
    localparam logic [1:0] ACK_RSVD   = 2'h0;

    // Half-cycle timing, in mclk cycles (one mclk = one half bus clock)
    localparam int HALF_NS      = 25;
    localparam int MCLK_NS      = 25;
    localparam int HALF_CYCLES  = (HALF_NS + MCLK_NS - 1) / MCLK_NS;

    // Reset values
    localparam logic [23:0] ADDR_RST = 24'h00_0000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // Request from the internal side
    typedef struct packed {
        logic [23:0] addr;
        logic [1:0]  len;      // Operand size in length encoding
        logic        write;
        logic        intAck;   // Interrupt-pin acknowledge cycle
        logic [31:0] wdata;    // Operand right-aligned
    } aebi_req_t;

    // Completion reported back to the internal side
    typedef struct packed {
        logic [31:0] rdata;
        logic        busErr;
        logic        autoVec;
        logic        misalign;
    } aebi_rsp_t;

    // Pin-facing control bundle
    typedef struct packed {
        logic [23:0] addr;
        logic [1:0]  len;
        logic        rnw;
        logic        addrStrobe;
        logic        dataStrobe;
    } aebi_pins_t;

endpackage

// *** rtl/aebi_lane_mux.sv ***
// Write byte-lane steering onto the sixteen data lines
`timescale 1ns/1ps
module aebi_lane_mux (
    // Operand and position
    input  wire logic [31:0] operand,
    input  wire logic [1:0]  doneBytes,
    input  wire logic [1:0]  remLen,
    input  wire logic        oddAddr,
    // Lanes
    output logic [15:0]      wrLanes
);
    logic [7:0] first;
    logic [7:0] second;
    logic [2:0] total;

    // Pick pending bytes by count already moved
    always_comb begin
        total  = (remLen == aebi_pkg::LEN_LONG) ? 3'h4 : {1'b0, remLen};
        total  = total + {1'b0, doneBytes};
        first  = operand[8'(total - 3'h1 - {1'b0, doneBytes}) * 8 +: 8];
        second = (total - {1'b0, doneBytes} > 3'h1) ?
                 operand[8'(total - 3'h2 - {1'b0, doneBytes}) * 8 +: 8] :
                 first;
        if (remLen == aebi_pkg::LEN_BYTE) begin
            wrLanes = {first, first};            // Copy on unused lane
        end else if (oddAddr) begin
            wrLanes = {first, first};
        end else begin
            wrLanes = {first, second};           // Upper then lower
        end
    end
endmodule

// *** rtl/aebi_master.sv ***
// Asynchronous external bus master with dynamic bus sizing
`timescale 1ns/1ps
module aebi_master #(
    parameter int MONITOR_CYCLES = 64
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // Internal request side
    input  wire logic                  reqValid,
    output logic                       reqReady,
    input  wire aebi_pkg::aebi_req_t   req,
    output logic                       rspValid,
    output aebi_pkg::aebi_rsp_t        rsp,
    // Bus control pins
    output aebi_pkg::aebi_pins_t       pins,
    // Data pins
    input  wire logic [15:0]           dataIn,
    output logic [15:0]                dataOut,
    output logic                       dataOe,
    // Termination pins, active low on the wire
    input  wire logic                  size_ack_1,
    input  wire logic                  size_ack_0,
    input  wire logic                  bus_fault_n,
    input  wire logic                  halt_n,
    input  wire logic                  auto_vector_req_n,
    // Bus error exception pulse
    output logic                       busErrExc
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_STROBE, ST_WAIT, ST_END
    } aebi_state_t;

    aebi_state_t state_reg;
    aebi_pkg::aebi_req_t cur_reg;
    logic [1:0]  done_reg;
    logic [1:0]  ack_s1_reg, ack_s2_reg;
    logic [2:0]  ctl_s1_reg, ctl_s2_reg;
    logic [15:0] dat_s1_reg;
    logic [15:0] dat_s2_reg;
    logic [31:0] rdata_reg;
    logic [15:0] mon_reg;
    logic        wrHalf_reg;
    logic        err_reg;
    logic        auto_vector_req_reg;
    logic [15:0] wrLanes;
    logic        faultSeen;
    logic        haltSeen;
    logic        avecSeen;
    logic        monTrip;
    logic        ackValid;
    logic        port8;
    logic        misalign;
    logic [1:0]  moved;
    logic [2:0]  remain;
    logic [2:0]  total;

    // Bytes in an operand given its length code
    function automatic logic [2:0] lenBytes(input logic [1:0] l);
        return (l == aebi_pkg::LEN_LONG) ? 3'h4 : {1'b0, l};
    endfunction

    // Two-flop synchronisers; only the second stage is read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_reg <= 2'h3;
            ack_s2_reg <= 2'h3;
            ctl_s1_reg <= 3'h7;
            ctl_s2_reg <= 3'h7;
            dat_s1_reg <= aebi_pkg::DATA_RST;
            dat_s2_reg <= aebi_pkg::DATA_RST;
        end else begin
            ack_s1_reg <= {size_ack_1, size_ack_0};   // Clocked sampling
            ack_s2_reg <= ack_s1_reg;
            ctl_s1_reg <= {bus_fault_n, halt_n, auto_vector_req_n};
            ctl_s2_reg <= ctl_s1_reg;
            dat_s1_reg <= dataIn;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    // Termination decode
    always_comb begin
        monTrip   = (mon_reg >= 16'(MONITOR_CYCLES)); // Before its readers
        faultSeen = !ctl_s2_reg[2] || monTrip;
        haltSeen  = !ctl_s2_reg[1];
        avecSeen  = !ctl_s2_reg[0] && cur_reg.intAck;
        ackValid  = (ack_s2_reg == aebi_pkg::ACK_PORT8) ||
                    (ack_s2_reg == aebi_pkg::ACK_PORT16);
        port8     = (ack_s2_reg == aebi_pkg::ACK_PORT8);
        misalign  = req.addr[0] && (req.len != aebi_pkg::LEN_BYTE);
        total     = lenBytes(cur_reg.len);
        remain    = total - {1'b0, done_reg};
        // At most one aligned word per cycle
        if (port8 || remain == 3'h1 || cur_reg.addr[0]) begin
            moved = 2'h1;
        end else begin
            moved = 2'h2;
        end
    end

    assign reqReady = (state_reg == ST_IDLE);

    // Cycle sequencing, one mclk per half bus clock
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (reqValid && !misalign) begin
                        state_reg <= ST_START;
                    end
                end
                ST_START:  state_reg <= ST_STROBE;
                ST_STROBE: state_reg <= ST_WAIT;
                ST_WAIT: begin
                    if (faultSeen || avecSeen || ackValid) begin
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    // Strobes are low here before any restart
                    if (!faultSeen && !avecSeen &&
                        remain > {1'b0, moved}) begin
                        state_reg <= ST_START;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Operand register, address and progress
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg  <= '0;
            done_reg <= 2'h0;
        end else if (state_reg == ST_IDLE && reqValid && !misalign) begin
            cur_reg  <= req;
            done_reg <= 2'h0;
        end else if (state_reg == ST_END && ackValid && !faultSeen) begin
            // Step address and remaining length
            cur_reg.addr <= cur_reg.addr + 24'({1'b0, moved});
            done_reg     <= done_reg + moved;
        end
    end

    // Bus monitor counts wait cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mon_reg <= 16'h0000;
        end else if (state_reg == ST_WAIT) begin
            mon_reg <= monTrip ? mon_reg : mon_reg + 16'h0001;
        end else begin
            mon_reg <= 16'h0000;
        end
    end

    // Read capture at the terminating edge, upper lane first
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == ST_START && done_reg == 2'h0) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == ST_WAIT && ackValid && !faultSeen &&
                     !cur_reg.write) begin
            if (moved == 2'h2) begin
                rdata_reg <= {rdata_reg[15:0], dat_s2_reg};
            end else if (!port8 && cur_reg.addr[0]) begin
                // Odd 16-bit byte on lower lane; copy ignored
                rdata_reg <= {rdata_reg[23:0], dat_s2_reg[7:0]};
            end else begin
                rdata_reg <= {rdata_reg[23:0], dat_s2_reg[15:8]};
            end
        end
    end

    // Completion status and exceptions
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            err_reg   <= 1'b0;
            auto_vector_req_reg  <= 1'b0;
            rspValid  <= 1'b0;
            rsp       <= '0;
            busErrExc <= 1'b0;
        end else begin
            rspValid  <= 1'b0;
            busErrExc <= 1'b0;
            if (state_reg == ST_IDLE && reqValid && misalign) begin
                rspValid     <= 1'b1;
                rsp          <= '0;
                rsp.misalign <= 1'b1;
            end else if (state_reg == ST_WAIT) begin
                err_reg  <= faultSeen;
                auto_vector_req_reg <= avecSeen && !faultSeen;
                busErrExc <= faultSeen && haltSeen;
            end else if (state_reg == ST_END &&
                         (faultSeen || err_reg || auto_vector_req_reg ||
                          remain <= {1'b0, moved})) begin
                rspValid    <= 1'b1;
                rsp.rdata   <= rdata_reg;
                rsp.busErr  <= err_reg;
                rsp.autoVec <= auto_vector_req_reg;
                rsp.misalign <= 1'b0;
            end
        end
    end

    // Pin outputs: address, length, direction and strobes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pins.addr       <= aebi_pkg::ADDR_RST;
            pins.len        <= aebi_pkg::LEN_BYTE;
            pins.rnw        <= 1'b1;
            pins.addrStrobe <= 1'b0;
            pins.dataStrobe <= 1'b0;
            wrHalf_reg      <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (reqValid && !misalign) begin
                        pins.addr <= req.addr;
                        pins.len  <= req.len;
                        pins.rnw  <= !req.write;
                    end
                end
                ST_START: begin
                    pins.addrStrobe <= 1'b1;
                    pins.dataStrobe <= !cur_reg.write;
                    pins.addr       <= cur_reg.addr;
                    pins.len        <= remain[1:0];
                end
                ST_STROBE: begin
                    wrHalf_reg <= cur_reg.write;
                end
                ST_WAIT: begin
                    if (cur_reg.write && wrHalf_reg) begin
                        pins.dataStrobe <= 1'b1;
                    end
                    if (faultSeen || avecSeen || ackValid) begin
                        pins.addrStrobe <= 1'b0;
                        pins.dataStrobe <= 1'b0;
                    end
                end
                ST_END: begin
                    wrHalf_reg <= 1'b0;
                end
                default: begin
                    pins.addrStrobe <= 1'b0;
                    pins.dataStrobe <= 1'b0;
                end
            endcase
        end
    end

    // Write data lanes, all sixteen lines driven
    aebi_lane_mux u_lanes (
        .operand   (cur_reg.wdata),
        .doneBytes (done_reg),
        .remLen    (remain[1:0]),
        .oddAddr   (cur_reg.addr[0]),
        .wrLanes   (wrLanes)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dataOut <= aebi_pkg::DATA_RST;
            dataOe  <= 1'b0;
        end else if (state_reg == ST_STROBE && cur_reg.write) begin
            dataOut <= wrLanes;
            dataOe  <= 1'b1;
        end else if (state_reg == ST_END || state_reg == ST_IDLE) begin
            dataOe  <= 1'b0;
        end
    end

    // Write data strobe follows address strobe by two half-clocks
    sequence s_write_start;
        $rose(pins.addrStrobe) && !pins.rnw;
    endsequence

    a_write_ds_delay: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_write_start |-> !pins.dataStrobe ##1 !pins.dataStrobe
                          ##1 pins.dataStrobe || !pins.addrStrobe)
        else $error("write data strobe timing wrong");

    a_read_ds_with: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(pins.addrStrobe) && pins.rnw |-> pins.dataStrobe)
        else $error("read data strobe not with address strobe");

    a_write_data_half: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_write_start |-> !dataOe ##1 dataOe)
        else $error("write data not half clock after strobe");

    a_as_half_clock: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_reg == ST_START |=> pins.addrStrobe)
        else $error("address strobe late");

    a_addr_stable: assert property (
        @(posedge mclk) disable iff (!reset_n)
        pins.addrStrobe && $past(pins.addrStrobe) |-> $stable(pins.addr))
        else $error("address moved under strobe");

    a_dir_stable: assert property (
        @(posedge mclk) disable iff (!reset_n)
        pins.addrStrobe |-> $stable(pins.rnw))
        else $error("direction changed under strobe");

    a_strobe_gap: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $fell(pins.addrStrobe) |-> !pins.dataStrobe ##1 !pins.addrStrobe)
        else $error("strobes not negated between cycles");

    a_no_misalign: assert property (
        @(posedge mclk) disable iff (!reset_n)
        pins.addrStrobe && done_reg == 2'h0 &&
        pins.len != aebi_pkg::LEN_BYTE |-> !pins.addr[0])
        else $error("misaligned operand on bus");

    a_write_all_lanes: assert property (
        @(posedge mclk) disable iff (!reset_n)
        pins.dataStrobe && !pins.rnw |-> dataOe)
        else $error("write lanes not driven");
endmodule

// *** verification/aebi_slave_model.sv ***
// Behavioural external slave with selectable port width and ending
`timescale 1ns/1ps
module aebi_slave_model (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // Bus from the master
    input  wire aebi_pkg::aebi_pins_t pins,
    input  wire logic [15:0]          dataOut,
    // Behaviour: port width; 0 ack, 1 fault, 2 silent
    input  wire logic                 port16,
    input  wire logic [1:0]           mode,
    // Answer pins
    output logic [15:0]               dataIn,
    output logic                      size_ack_1,
    output logic                      size_ack_0,
    output logic                      bus_fault_n
);
    logic [7:0]  mem [16];
    logic [15:0] lastData;
    logic [1:0]  waitCnt;
    logic [3:0]  a;
    logic        go;
    logic        idle;
    logic        fire;

    assign a    = pins.addr[3:0];
    // A write is answered only once data strobe marks data valid
    assign go   = pins.rnw ? pins.addrStrobe : pins.dataStrobe;
    assign idle = size_ack_1 & size_ack_0 & bus_fault_n;
    assign fire = go & idle & (waitCnt == 2'h2);

    // Fixed lanes; an unconnected or released lane keeps toggling
    always_comb begin
        if (pins.rnw && pins.addrStrobe) begin
            if (port16)
                dataIn = {mem[{a[3:1], 1'h0}], mem[{a[3:1], 1'h1}]};
            else
                dataIn = {mem[a], ~lastData[7:0]};
        end else begin
            dataIn = ~lastData;
        end
    end

    // History for the toggling pattern
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            lastData <= 16'h0000;
        else
            lastData <= dataIn;
    end

    // Two wait states, then the ending that mode selects
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {size_ack_1, size_ack_0} <= 2'h3;
            bus_fault_n <= 1'h1;
            waitCnt <= 2'h0;
        end else if (!pins.addrStrobe) begin
            {size_ack_1, size_ack_0} <= 2'h3;
            bus_fault_n <= 1'h1;
            waitCnt <= 2'h0;
        end else if (go && idle) begin
            if (waitCnt != 2'h2)
                waitCnt <= waitCnt + 2'h1;
            else if (mode == 2'h1)
                bus_fault_n <= 1'h0;
            else if (mode == 2'h0)
                {size_ack_1, size_ack_0} <= port16 ? 2'h1 : 2'h2;
        end
    end

    // Store write bytes as the acknowledge goes out
    always_ff @(posedge mclk) begin
        if (fire && !pins.rnw && mode == 2'h0) begin
            if (!port16)
                mem[a] <= dataOut[15:8];
            else if (pins.len == aebi_pkg::LEN_BYTE)
                mem[a] <= a[0] ? dataOut[7:0] : dataOut[15:8];
            else begin
                mem[{a[3:1], 1'h0}] <= dataOut[15:8];
                mem[{a[3:1], 1'h1}] <= dataOut[7:0];
            end
        end
    end
endmodule

// *** verification/test_aebi_master.sv ***
// Self-checking bench for the external bus master
`timescale 1ns/1ps
module test_aebi_master;
    logic                 mclk, reset_n, reqValid, reqReady, rspValid;
    logic                 dataOe, busErrExc, halt_n, auto_vector_req_n;
    logic                 port16, size_ack_1, size_ack_0, bus_fault_n;
    logic                 asLast, oeOk;
    logic [1:0]           mode;
    logic [15:0]          dataIn, dataOut, lastWr;
    logic [23:0]          cycAddr [4];
    logic [1:0]           cycLen [4];
    aebi_pkg::aebi_req_t  req;
    aebi_pkg::aebi_rsp_t  rsp, rs;
    aebi_pkg::aebi_pins_t pins;
    int                   nCyc, excCnt, errorCnt, cmpCount;

    aebi_master #(.MONITOR_CYCLES(8)) i_aebi_master (
        .mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp),
        .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .size_ack_1(size_ack_1), .size_ack_0(size_ack_0),
        .bus_fault_n(bus_fault_n), .halt_n(halt_n),
        .auto_vector_req_n(auto_vector_req_n), .busErrExc(busErrExc));

    aebi_slave_model i_aebi_slave_model (
        .mclk(mclk), .reset_n(reset_n), .pins(pins), .dataOut(dataOut),
        .port16(port16), .mode(mode), .dataIn(dataIn),
        .size_ack_1(size_ack_1), .size_ack_0(size_ack_0),
        .bus_fault_n(bus_fault_n));

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    // Log each bus cycle, the write lanes and exception pulses
    always @(posedge mclk) begin
        if (pins.addrStrobe && !asLast && nCyc < 4) begin
            cycAddr[nCyc] = pins.addr;
            cycLen[nCyc] = pins.len;
        end
        if (pins.addrStrobe && !asLast)
            nCyc++;
        if (pins.dataStrobe && !pins.rnw) begin
            lastWr = dataOut;
            oeOk = oeOk & dataOe;
        end
        if (busErrExc === 1'h1)
            excCnt++;
        asLast = pins.addrStrobe;
    end

    task automatic results();
        if (errorCnt == 0 && cmpCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp, input string what);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // One operand request, waited on under a bound
    task automatic op(input logic [23:0] ad, input logic [1:0] ln,
                      input logic wr, input logic ia, input logic [31:0] wd);
        int   n;
        logic rdy;
        @(negedge mclk);
        req = '{ad, ln, wr, ia, wd};
        reqValid = 1'h1;
        nCyc = 0;
        excCnt = 0;
        oeOk = 1'h1;
        n = 0;
        do begin
            rdy = reqReady;
            @(negedge mclk);
            n++;
        end while (rdy !== 1'h1 && n < 200);
        reqValid = 1'h0;
        n = (rdy === 1'h1) ? 0 : 300;
        while (rspValid !== 1'h1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 300) begin
            chk(32'h0, 32'h1, "timeout");
            results();
        end
        rs = rsp;
    endtask

    // Long word on a 16-bit port: two cycles, high word first
    task automatic long16();
        port16 = 1'h1;
        op(24'h00_0004, aebi_pkg::LEN_LONG, 1'h1, 1'h0, 32'h1234_5678);
        chk(nCyc, 32'h2, "l16 cycles");
        chk(cycAddr[0], 32'h4, "l16 byte_select_lsb");
        chk(cycLen[0], aebi_pkg::LEN_LONG, "l16 len0");
        chk(cycAddr[1], 32'h6, "l16 addr1");
        chk(cycLen[1], aebi_pkg::LEN_WORD, "l16 len1");
        chk(lastWr, 32'h5678, "l16 lanes");
        chk(oeOk, 32'h1, "l16 drive");
        chk(i_aebi_slave_model.mem[4], 32'h12, "l16 stored");
        op(24'h00_0004, aebi_pkg::LEN_LONG, 1'h0, 1'h0, 32'h0);
        chk(rs.rdata, 32'h1234_5678, "l16 read");
    endtask

    // Long word on an 8-bit port: four byte cycles
    task automatic long8();
        port16 = 1'h0;
        op(24'h00_0008, aebi_pkg::LEN_LONG, 1'h1, 1'h0, 32'h9ABC_DEF0);
        chk(nCyc, 32'h4, "l8 cycles");
        chk(cycLen[1], aebi_pkg::LEN_THREE, "l8 len1");
        chk(cycAddr[3], 32'hB, "l8 addr3");
        chk(cycLen[3], aebi_pkg::LEN_BYTE, "l8 len3");
        chk(lastWr[15:8], 32'hF0, "l8 lane");
        op(24'h00_0008, aebi_pkg::LEN_LONG, 1'h0, 1'h0, 32'h0);
        chk(rs.rdata, 32'h9ABC_DEF0, "l8 read");
    endtask

    // Byte lanes on odd addresses for both port widths
    task automatic lanes();
        port16 = 1'h1;
        op(24'h00_0002, aebi_pkg::LEN_WORD, 1'h1, 1'h0, 32'hC3A5);
        op(24'h00_0003, aebi_pkg::LEN_BYTE, 1'h1, 1'h0, 32'h5A);
        chk(lastWr, 32'h5A5A, "byte copy");
        chk(cycAddr[0], 32'h3, "byte addr");
        chk(nCyc, 32'h1, "byte cycles");
        op(24'h00_0002, aebi_pkg::LEN_WORD, 1'h0, 1'h0, 32'h0);
        chk(rs.rdata, 32'hC35A, "word read");
        op(24'h00_0003, aebi_pkg::LEN_BYTE, 1'h0, 1'h0, 32'h0);
        chk(rs.rdata, 32'h5A, "odd16 read");
        port16 = 1'h0;
        op(24'h00_0003, aebi_pkg::LEN_BYTE, 1'h0, 1'h0, 32'h0);
        chk(rs.rdata, 32'h5A, "byte8 read");
    endtask

    // Odd word and long are refused with no bus cycle
    task automatic misalign();
        op(24'h00_0005, aebi_pkg::LEN_WORD, 1'h0, 1'h0, 32'h0);
        chk(rs.misalign, 32'h1, "odd word");
        op(24'h00_0007, aebi_pkg::LEN_LONG, 1'h1, 1'h0, 32'h0);
        chk({rs.misalign, nCyc[3:0]}, 32'h10, "odd long");
    endtask

    // Fault endings, with and without halt, and a silent slave
    task automatic faults();
        mode = 2'h1;
        op(24'h00_0004, aebi_pkg::LEN_WORD, 1'h0, 1'h0, 32'h0);
        chk({rs.busErr, excCnt[3:0]}, 32'h10, "fault");
        halt_n = 1'h0;
        op(24'h00_0004, aebi_pkg::LEN_WORD, 1'h0, 1'h0, 32'h0);
        chk({rs.busErr, excCnt[3:0]}, 32'h11, "fault halt");
        halt_n = 1'h1;
        mode = 2'h2;
        op(24'h00_0004, aebi_pkg::LEN_WORD, 1'h0, 1'h0, 32'h0);
        chk(rs.busErr, 32'h1, "monitor");
    endtask

    // Autovector ends acknowledge cycles only
    task automatic autovec();
        auto_vector_req_n = 1'h0;
        op(24'h00_0004, aebi_pkg::LEN_BYTE, 1'h0, 1'h1, 32'h0);
        chk({rs.autoVec, rs.busErr}, 32'h2, "auto_vector_req ack");
        mode = 2'h0;
        op(24'h00_0003, aebi_pkg::LEN_BYTE, 1'h0, 1'h0, 32'h0);
        chk({rs.autoVec, rs.rdata[30:0]}, 32'h5A, "auto_vector_req other");
        auto_vector_req_n = 1'h1;
    endtask

    initial begin
        reqValid = 1'h0;
        req = '0;
        reset_n = 1'h0;
        halt_n = 1'h1;
        auto_vector_req_n = 1'h1;
        port16 = 1'h1;
        mode = 2'h0;
        asLast = 1'h0;
        nCyc = 0;
        errorCnt = 0;
        cmpCount = 0;
        repeat (6) @(negedge mclk);
        reset_n = 1'h1;
        long16();
        long8();
        lanes();
        misalign();
        faults();
        autovec();
        results();
    end
endmodule
